// >>> design/dsl_clock_generator_config.sv
/*
 * payload clock generator with its indirect configuration pair
 * assumes: avalon-mm master with byte addresses; reference and port
 * receive clocks arrive as slow pins sampled on the system clock
 */
// Register access over Avalon-MM was decided locally.
// How it works
// (RQ1) selector picks an element; data writes program that element
// (RQ2) prescaler factor is numerator over terminal count plus one
// (RQ3) intermediate rate is input clock rate times prescaler factor
// (RQ4) intermediate clock divided by 257 plus divisor gives 8 khz
// (RQ5) each payload rate is 8 kbps times its multiplier factor
// (RQ6) software keeps intermediate between top payload rate and sysclk/16
// (RQ7) software typically uses 2.56 mhz with denominator 320
// (RQ8) selector bits 7-5 choose element type, reset zero
// (RQ9) types 4/5: bit 4 picks rx or tx group, bits 3-0 group
// (RQ10) types 6/7: bits 4-0 pick the synthesizer port
// (RQ11) software writes zero to selector bits 4-0 for types 0-3
// (RQ12) basic bit 6 picks external rx clocks or internal synthesizers
// (RQ13) basic bit 5 picks sysclk/24 or generator outputs for selectors
// (RQ14) basic bit 4 picks system clock or reference clock as input
// (RQ15) type 1 holds prescaler terminal count, denominator is it plus one
// (RQ16) type 2 holds the prescaler numerator
// (RQ17) type 3 value plus 257 sets the reference divider count
// (RQ18) factors are nine bits: low byte 8 kbps, top bit 2048 kbps
// (RQ19) prescaler is an accumulator pulsing on wrap past the denominator
// (RQ20) payload enables give factor pulses per 8 khz period
`timescale 1ns/1ps
`include "clkgen_map.svh"
module dsl_clock_generator_config
	import clkgen_pkg::*;
(
	input  wire logic        CLK_SYS_I,
	input  wire logic        RESET_N_I,
	input  wire logic [12:0] ADDRESS_I,
	input  wire logic        READ_I,
	input  wire logic        WRITE_I,
	input  wire logic [31:0] WRITEDATA_I,
	input  wire logic [3:0]  BYTEENABLE_I,
	output logic      [31:0] READDATA_O,
	output logic             WAITREQUEST_O,
	input  wire logic        CORE_REFERENCE_CLOCK_I,
	input  wire logic [31:0] PORT_RX_CLOCK_IN_I,
	output logic             INTERMEDIATE_EN_O,
	output logic             TIMEBASE_8K_EN_O,
	output logic      [15:0] GROUP_RX_CLK_EN_O,
	output logic      [15:0] GROUP_TX_CLK_EN_O,
	output logic             TX_TIMING_REFERENCE_EN_O,
	output logic      [31:0] PORT_RX_CLK_EN_O
);

	state_s           q;
	state_s           next_q;
	logic [63:0][8:0] factors;
	logic [63:0]      gen_pulse;
	logic [9:0]       ref_den;
	logic [32:0]      agree;
	logic [32:0]      rise;
	logic             in_tick;
	logic [9:0]       pre_sum;
	logic [8:0]       pre_den;
	logic [8:0]       ref_tc;
	logic [2:0]       etype;
	logic [3:0]       grp_idx;
	logic [4:0]       port_idx;
	logic [7:0]       wbyte;
	logic [1:0]       hit;

	////////////////////////////////////////////////////////////////////////

	function automatic logic [2:0] type_of(input logic [7:0] s);
		type_of = s[`CG_TYPE_HI:`CG_TYPE_LO]; // [RQ8]
	endfunction : type_of

	// readback of the element the selector points at; reserved bits zero
	function automatic logic [7:0] read_element(input state_s s);
		logic [3:0] g;
		logic [4:0] p;
		g = s.sel[`CG_GRP_HI:0];
		p = s.sel[`CG_PORT_HI:0];
		read_element = 8'h00;
		case (type_of(s.sel))
			3'h0: read_element = {1'b0, s.basic, 4'h0};
			3'h1: read_element = s.pre_tc;
			3'h2: read_element = s.pre_num;
			3'h3: read_element = s.ref_div;
			3'h4: read_element = s.sel[`CG_DIR_BIT] ?
				s.grp_tx[g][7:0] : s.grp_rx[g][7:0];
			3'h5: read_element = {7'h00, s.sel[`CG_DIR_BIT] ?
				s.grp_tx[g][8] : s.grp_rx[g][8]};
			3'h6: read_element = s.port_f[p][7:0];
			default: read_element = {7'h00, s.port_f[p][8]};
		endcase
	endfunction : read_element

	// register decode shared by read capture and write commit
	function automatic logic [1:0] reg_hit(input logic [12:0] a);
		if (a == `CG_SEL_ADDR) begin
			reg_hit = 2'b01;
		end else if (a == `CG_DATA_ADDR) begin
			reg_hit = 2'b10;
		end else begin
			reg_hit = 2'b00;
		end
	endfunction : reg_hit

	////////////////////////////////////////////////////////////////////////

	// denominator up to 512 so ten bits [RQ4] [RQ17]
	assign ref_den = {2'b00, q.ref_div} + `CG_REF_BASE;
	// factor order: rx groups, tx groups, ports [RQ18]
	assign factors = {q.port_f, q.grp_tx, q.grp_rx};

	genvar gi;
	generate
		for (gi = 0; gi < 64; gi++) begin : g_pay
			payload_pulse_gen u_pay (
				.clk_i     (CLK_SYS_I),
				.reset_n_i (RESET_N_I),
				.tick_i    (q.inter),
				.frame_i   (q.frame),
				.factor_i  (factors[gi]),
				.den_i     (ref_den),
				.pulse_o   (gen_pulse[gi])
			); // [RQ5] [RQ20]
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////

	always_comb begin
		next_q = q;
		etype = type_of(q.sel);
		grp_idx = q.sel[`CG_GRP_HI:0];
		port_idx = q.sel[`CG_PORT_HI:0];
		wbyte = WRITEDATA_I[7:0];
		hit = reg_hit(ADDRESS_I);

		// pin sampling: a change counts once stages two and three agree
		next_q.s1 = {CORE_REFERENCE_CLOCK_I, PORT_RX_CLOCK_IN_I};
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
		agree = ~(q.s2 ^ q.s3);
		next_q.lvl = (agree & q.s3) | (~agree & q.lvl);
		rise = agree & q.s3 & ~q.lvl;

		// bus: one wait cycle, then the answer stands for one cycle
		case (q.bus)
			BUS_IDLE: begin
				if (READ_I || WRITE_I) begin
					next_q.bus = BUS_ACK;
					next_q.rdata = 8'h00;
					if (hit[0]) begin
						next_q.rdata = q.sel;
					end else if (hit[1]) begin
						next_q.rdata = read_element(q);
					end
				end
			end
			BUS_ACK: begin
				next_q.bus = BUS_IDLE;
				if (WRITE_I && BYTEENABLE_I[0]) begin
					if (hit[0]) begin
						next_q.sel = wbyte; // [RQ1] [RQ8]
					end else if (hit[1]) begin
						case (etype) // [RQ1]
							3'h0: next_q.basic =
								wbyte[`CG_SYNTH_BIT:`CG_INSEL_BIT];
							3'h1: next_q.pre_tc = wbyte; // [RQ15]
							3'h2: next_q.pre_num = wbyte; // [RQ16]
							3'h3: next_q.ref_div = wbyte; // [RQ17]
							3'h4: begin
								if (q.sel[`CG_DIR_BIT]) begin // [RQ9]
									next_q.grp_tx[grp_idx][7:0] = wbyte;
								end else begin
									next_q.grp_rx[grp_idx][7:0] = wbyte;
								end
							end
							3'h5: begin
								if (q.sel[`CG_DIR_BIT]) begin // [RQ9]
									next_q.grp_tx[grp_idx][8] = wbyte[0];
								end else begin
									next_q.grp_rx[grp_idx][8] = wbyte[0];
								end
							end
							3'h6: begin
								next_q.port_f[port_idx][7:0] = wbyte; // [RQ10]
							end
							default: begin
								next_q.port_f[port_idx][8] = wbyte[0]; // [RQ10]
							end
						endcase
					end
				end
			end
			default: next_q.bus = BUS_IDLE;
		endcase

		// input clock choice; system clock ticks every cycle [RQ14]
		in_tick = q.basic[2'(`CG_INSEL_BIT - 4)] ? rise[32] : 1'b1;

		// fractional prescaler; numerator above denominator saturates
		pre_den = {1'b0, q.pre_tc} + 9'h001; // [RQ2] [RQ15]
		pre_sum = {1'b0, q.pre_acc} + {2'b00, q.pre_num};
		next_q.inter = 1'b0;
		if (in_tick) begin
			if (pre_sum >= {1'b0, pre_den}) begin // [RQ19]
				next_q.pre_acc = 9'(pre_sum - {1'b0, pre_den});
				next_q.inter = 1'b1; // [RQ3]
			end else begin
				next_q.pre_acc = pre_sum[8:0];
			end
		end

		// reference divider: 257 plus divisor intermediate ticks
		ref_tc = {1'b0, q.ref_div} + `CG_REF_TC_BASE;
		next_q.frame = 1'b0;
		if (next_q.inter) begin
			if (q.ref_cnt >= ref_tc) begin // [RQ4] [RQ17]
				next_q.ref_cnt = 9'h000;
			end else begin
				next_q.ref_cnt = q.ref_cnt + 9'h001;
			end
			next_q.frame = (q.ref_cnt >= ref_tc);
		end

		// fixed sysclk/24 fallback timebase
		next_q.sys24 = 1'b0;
		if (q.div24 == 5'(`CG_SYS_DIV - 5'h01)) begin
			next_q.div24 = 5'h00;
			next_q.sys24 = 1'b1;
		end else begin
			next_q.div24 = q.div24 + 5'h01;
		end

		// output selectors [RQ12] [RQ13]
		if (q.basic[2'(`CG_SUBST_BIT - 4)]) begin
			next_q.grp_rx_o = gen_pulse[15:0];
			next_q.grp_tx_o = gen_pulse[31:16];
			next_q.trl_o = q.frame;
		end else begin
			next_q.grp_rx_o = {16{q.sys24}};
			next_q.grp_tx_o = {16{q.sys24}};
			next_q.trl_o = q.sys24;
		end
		if (q.basic[2'(`CG_SYNTH_BIT - 4)]) begin
			next_q.port_o = gen_pulse[63:32];
		end else begin
			next_q.port_o = rise[31:0];
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			q <= '0;
			q.bus <= BUS_IDLE;
			q.sel <= `CG_SEL_RST;
		end else begin
			q <= next_q;
		end
	end

	////////////////////////////////////////////////////////////////////////

	// combinational wait keeps the answer a fixed single cycle late
	assign WAITREQUEST_O = (READ_I | WRITE_I) & (q.bus != BUS_ACK);
	assign READDATA_O = {24'h000000, q.rdata};
	assign INTERMEDIATE_EN_O = q.inter;
	assign TIMEBASE_8K_EN_O = q.frame;
	assign GROUP_RX_CLK_EN_O = q.grp_rx_o;
	assign GROUP_TX_CLK_EN_O = q.grp_tx_o;
	assign TX_TIMING_REFERENCE_EN_O = q.trl_o;
	assign PORT_RX_CLK_EN_O = q.port_o;

endmodule : dsl_clock_generator_config

// >>> shared/clkgen_map.svh
/*
 * offsets, field positions, reset values and counts of the clock generator
 * assumes: included by bare name from design and bench files
 */
`ifndef CLKGEN_MAP_SVH
`define CLKGEN_MAP_SVH

// register indices; the byte address is four times the index
`define CG_SEL_IDX      11'h416
`define CG_DATA_IDX     11'h417
`define CG_SEL_ADDR     ({`CG_SEL_IDX, 2'b00})
`define CG_DATA_ADDR    ({`CG_DATA_IDX, 2'b00})

// selector fields
`define CG_TYPE_HI      7
`define CG_TYPE_LO      5
`define CG_DIR_BIT      4
`define CG_GRP_HI       3
`define CG_PORT_HI      4

// basic setup fields
`define CG_SYNTH_BIT    6
`define CG_SUBST_BIT    5
`define CG_INSEL_BIT    4

// reset values
`define CG_SEL_RST      8'h00
`define CG_DATA_RST     8'h00

// counts
`define CG_SYS_DIV      5'h18
`define CG_REF_BASE     10'h101
`define CG_REF_TC_BASE  9'h100

`endif

// >>> shared/clkgen_pkg.sv
/*
 * types of the clock generator: bus states and state records
 * assumes: compiled before the design modules
 */
package clkgen_pkg;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_state_e;

	typedef struct packed {
		bus_state_e        bus;
		logic [7:0]        rdata;
		logic [7:0]        sel;
		logic [2:0]        basic;
		logic [7:0]        pre_tc;
		logic [7:0]        pre_num;
		logic [7:0]        ref_div;
		logic [15:0][8:0]  grp_rx;
		logic [15:0][8:0]  grp_tx;
		logic [31:0][8:0]  port_f;
		logic [32:0]       s1;
		logic [32:0]       s2;
		logic [32:0]       s3;
		logic [32:0]       lvl;
		logic [8:0]        pre_acc;
		logic              inter;
		logic [8:0]        ref_cnt;
		logic              frame;
		logic [4:0]        div24;
		logic              sys24;
		logic [15:0]       grp_rx_o;
		logic [15:0]       grp_tx_o;
		logic              trl_o;
		logic [31:0]       port_o;
	} state_s;

	typedef struct packed {
		logic [9:0] acc;
		logic       pulse;
	} pulse_s;

endpackage : clkgen_pkg

// >>> design/payload_pulse_gen.sv
/*
 * one payload clock enable: factor pulses per 8 khz period
 * assumes: tick_i is the intermediate enable, frame_i marks its last tick
 * of each 8 khz period, den_i is the reference denominator
 */
`timescale 1ns/1ps
module payload_pulse_gen
	import clkgen_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       tick_i,
	input  wire logic       frame_i,
	input  wire logic [8:0] factor_i,
	input  wire logic [9:0] den_i,
	output logic            pulse_o
);

	pulse_s      q;
	pulse_s      next_q;
	logic [10:0] sum;

	always_comb begin
		next_q = q;
		next_q.pulse = 1'b0;
		sum = {1'b0, q.acc} + {2'b00, factor_i};
		if (tick_i) begin
			// wrap past the denominator gives one pulse [RQ20]
			if (sum >= {1'b0, den_i}) begin
				next_q.acc = 10'(sum - {1'b0, den_i});
				next_q.pulse = 1'b1;
			end else begin
				next_q.acc = sum[9:0];
			end
			// realign each period so a factor change lands cleanly
			if (frame_i) begin
				next_q.acc = 10'h000;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign pulse_o = q.pulse;

endmodule : payload_pulse_gen

// >>> tb/dsl_clock_generator_config_props.sv
/* checker: bus handshake and pulse outputs of the generator
   assumes: bound to the top module, one clock domain */
`timescale 1ns/1ps
module dsl_clock_generator_config_props (
	input wire logic        CLK_SYS_I,
	input wire logic        RESET_N_I,
	input wire logic        READ_I,
	input wire logic        WRITE_I,
	input wire logic [31:0] READDATA_O,
	input wire logic        WAITREQUEST_O,
	input wire logic        INTERMEDIATE_EN_O,
	input wire logic        TIMEBASE_8K_EN_O,
	input wire logic        TX_TIMING_REFERENCE_EN_O,
	input wire logic [15:0] GROUP_RX_CLK_EN_O
);
	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (!RESET_N_I);
	wire req = READ_I || WRITE_I;
	sequence s_req_rise;
		$rose(req);
	endsequence
	sequence s_one_wait;
		WAITREQUEST_O ##1 !WAITREQUEST_O;
	endsequence
	sequence s_idle2;
		!req ##1 !req;
	endsequence
	//////////////////////////////////////////////////////////////////
	a_wait_one: assert property (s_req_rise |-> s_one_wait)
		else $error("wait state count wrong");
	a_wait_idle: assert property (!req |-> !WAITREQUEST_O)
		else $error("waitrequest without request");
	a_ack_once: assert property (
		req && !WAITREQUEST_O |=> !req || WAITREQUEST_O)
		else $error("second ack for one request");
	a_read_upper: assert property (
		READ_I && !WAITREQUEST_O |-> READDATA_O[31:8] == 24'h0)
		else $error("upper read bits set");
	a_data_hold: assert property (s_idle2 |-> $stable(READDATA_O))
		else $error("read data moved while idle");
	a_reset_quiet: assert property ($rose(RESET_N_I) |->
		!INTERMEDIATE_EN_O && !TIMEBASE_8K_EN_O && GROUP_RX_CLK_EN_O == 16'h0)
		else $error("output active after reset");
	a_frame_gap: assert property (
		TIMEBASE_8K_EN_O |=> !TIMEBASE_8K_EN_O [*8])
		else $error("timebase pulses too close");
	a_txref_gap: assert property (
		TX_TIMING_REFERENCE_EN_O |=> !TX_TIMING_REFERENCE_EN_O [*8])
		else $error("tx reference pulses too close");
endmodule : dsl_clock_generator_config_props
//////////////////////////////////////////////////////////////////////
bind dsl_clock_generator_config dsl_clock_generator_config_props i_props (
	.CLK_SYS_I, .RESET_N_I, .READ_I, .WRITE_I, .READDATA_O,
	.WAITREQUEST_O, .INTERMEDIATE_EN_O, .TIMEBASE_8K_EN_O,
	.TX_TIMING_REFERENCE_EN_O, .GROUP_RX_CLK_EN_O);

// >>> tb/dsl_clock_generator_config_tb_top.sv
/* bench: register pair over avalon-mm, then pulse counts per window
   assumes: one clock; counts taken in steady state over whole periods */
`timescale 1ns/1ps
`include "clkgen_map.svh"
`define CHK(n,e,g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
	$display("Error %s exp %0h got %0h", n, e, g); end end
module dsl_clock_generator_config_tb_top;
	logic        clk, rst_n, rd, wr, refc, wait_o, inter, tb8, txr;
	logic [12:0] adr;
	logic [31:0] wd, q, rdata, prx;
	logic [3:0]  be;
	logic [15:0] grx, gtx;
	int          err_count, n_tests, rk;
	int          c[6];
	dsl_clock_generator_config i_dut (.CLK_SYS_I(clk), .RESET_N_I(rst_n),
		.ADDRESS_I(adr), .READ_I(rd), .WRITE_I(wr), .WRITEDATA_I(wd),
		.BYTEENABLE_I(be), .READDATA_O(rdata), .WAITREQUEST_O(wait_o),
		.CORE_REFERENCE_CLOCK_I(refc), .PORT_RX_CLOCK_IN_I({32{refc}}),
		.INTERMEDIATE_EN_O(inter), .TIMEBASE_8K_EN_O(tb8),
		.GROUP_RX_CLK_EN_O(grx), .GROUP_TX_CLK_EN_O(gtx),
		.TX_TIMING_REFERENCE_EN_O(txr), .PORT_RX_CLK_EN_O(prx));
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	// slow pin: one rising edge every 32 cycles, below sysclk/16
	always @(posedge clk) begin
		rk <= (rk == 15) ? 0 : rk + 1;
		if (rk == 15) refc <= ~refc;
	end
	//////////////////////////////////////////////////////////////////
	task close_out;
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : close_out
	// holds the request until waitrequest is seen low at an edge
	task bus(input logic w, input logic [12:0] a, input logic [7:0] d,
		input logic [3:0] e);
		int k;
		@(posedge clk);
		wr <= w;
		rd <= !w;
		adr <= a;
		wd <= {24'h0, d};
		be <= e;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (wait_o !== 1'b0 && k < 20);
		if (wait_o !== 1'b0) begin
			err_count++;
			close_out();
		end
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	task put(input logic [7:0] s, input logic [7:0] d);
		bus(1'b1, `CG_SEL_ADDR, s, 4'hf);
		bus(1'b1, `CG_DATA_ADDR, d, 4'hf);
	endtask : put
	task get(input logic [7:0] s);
		bus(1'b1, `CG_SEL_ADDR, s, 4'hf);
		bus(1'b0, `CG_DATA_ADDR, 8'h00, 4'hf);
	endtask : get
	task cnt(input int n);
		c = '{default: 0};
		repeat (n) begin
			@(posedge clk);
			c[0] += inter;
			c[1] += tb8;
			c[2] += grx[0];
			c[3] += gtx[1];
			c[4] += txr;
			c[5] += prx[0];
		end
	endtask : cnt
	//////////////////////////////////////////////////////////////////
	task t_reset;
		bus(1'b0, `CG_SEL_ADDR, 8'h00, 4'hf);
		`CHK("sel", 32'h0, q)
		bus(1'b0, `CG_DATA_ADDR, 8'h00, 4'hf);
		`CHK("data", 32'h0, q)
	endtask : t_reset
	task t_regs;
		logic [7:0] s;
		logic [7:0] e;
		for (int t = 0; t < 8; t++) begin
			s = {t[2:0], (t < 4) ? 5'h00 : 5'h03};
			e = (t == 0) ? 8'h50 : (t == 5 || t == 7) ? 8'h01 : 8'h5b;
			put(s, 8'h5b);
			bus(1'b0, `CG_SEL_ADDR, 8'h00, 4'hf);
			`CHK("sel", {24'h0, s}, q)
			get(s);
			`CHK("element", {24'h0, e}, q)
		end
		get(8'h20);
		`CHK("tc kept", 32'h5b, q)
		bus(1'b0, 13'h0000, 8'h00, 4'hf);
		`CHK("unmapped", 32'h0, q)
		// lane 0 disabled: must be ignored
		bus(1'b1, `CG_DATA_ADDR, 8'h11, 4'he);
		get(8'h20);
		`CHK("be0", 32'h5b, q)
		put(8'hb2, 8'h01);
		get(8'hb2);
		`CHK("tx msb", 32'h1, q)
		// drop msbs so every factor fits the later denominators
		put(8'ha3, 8'h00);
		put(8'he3, 8'h00);
	endtask : t_regs
	task t_presc;
		put(8'h00, 8'h00);
		put(8'h60, 8'h00);
		put(8'h20, 8'h0f);
		put(8'h40, 8'h01);
		cnt(96);
		cnt(480);
		`CHK("inter 1/16", 30, c[0])
		`CHK("grp sys24", 20, c[2])
		`CHK("txref sys24", 20, c[4])
		put(8'h20, 8'h3f);
		put(8'h40, 8'h03);
		cnt(48);
		cnt(320);
		`CHK("inter 3/64", 15, c[0])
		put(8'h40, 8'h00);
		cnt(48);
		cnt(300);
		`CHK("num zero", 0, c[0])
	endtask : t_presc
	task t_frame;
		// switch outputs while the numerator is zero: no early tick
		put(8'h00, 8'h60);
		put(8'h20, 8'h0f);
		put(8'h40, 8'h01);
		put(8'h80, 8'h05);
		put(8'h91, 8'h07);
		put(8'hc0, 8'h00);
		put(8'he0, 8'h01);
		// windows are whole periods, so phase does not matter
		cnt(4300);
		cnt(8224);
		`CHK("inter", 514, c[0])
		`CHK("8k", 2, c[1])
		`CHK("grp rx0", 10, c[2])
		`CHK("grp tx1", 14, c[3])
		`CHK("txref 8k", 2, c[4])
		`CHK("port0", 512, c[5])
		put(8'h60, 8'h3f);
		cnt(5300);
		cnt(10240);
		`CHK("inter 320", 640, c[0])
		`CHK("8k den 320", 2, c[1])
	endtask : t_frame
	task t_ref;
		// stop the timebase first so the tx reference gap holds
		put(8'h40, 8'h00);
		cnt(16);
		put(8'h00, 8'h10);
		put(8'h20, 8'h00);
		put(8'h40, 8'h01);
		cnt(100);
		cnt(640);
		`CHK("ref edges", 20, c[0])
		`CHK("ext rx", 20, c[5])
	endtask : t_ref
	//////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		adr = 13'h0;
		wd = 32'h0;
		be = 4'hf;
		refc = 1'b0;
		rk = 0;
		err_count = 0;
		n_tests = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_regs();
		t_presc();
		t_frame();
		t_ref();
		close_out();
	end
endmodule : dsl_clock_generator_config_tb_top
